/* include/wsr_pkg.sv */
// Package of constants and types for the word shift and rotate unit.
`default_nettype none
package wsr_pkg;
   // Word width and bus geometry.
   localparam int unsigned WORD_W        = 16;
   localparam int unsigned AXI_AW        = 8;
   localparam int unsigned AXI_DW        = 32;
   // Operation codes as issued by the sequencer.
   localparam logic [7:0]  OP_SHL        = 8'h25;
   localparam logic [7:0]  OP_SHR        = 8'h26;
   localparam logic [7:0]  OP_ROL        = 8'h27;
   localparam logic [7:0]  OP_SET_CARRY  = 8'h40;
   localparam logic [7:0]  OP_CLR_CARRY  = 8'h41;
   // Register byte offsets.
   localparam logic [7:0]  REG_CTRL      = 8'h00;
   localparam logic [7:0]  REG_OPERAND   = 8'h04;
   localparam logic [7:0]  REG_RESULT    = 8'h08;
   localparam logic [7:0]  REG_FLAGS     = 8'h0C;
   localparam logic [7:0]  REG_IRQ_STAT  = 8'h10;
   localparam logic [7:0]  REG_IRQ_MASK  = 8'h14;
   // Control register fields: op code in 7:0, execution condition in 8.
   localparam int unsigned CTRL_OP_LSB   = 0;
   localparam int unsigned CTRL_COND_BIT = 8;
   // Flag bit positions in the flags register; status and mask registers use the IRQ bits.
   localparam int unsigned FLG_ERR       = 0;
   localparam int unsigned FLG_ZERO      = 1;
   localparam int unsigned FLG_CARRY     = 2;
   localparam int unsigned FLG_NEG       = 3;
   localparam int unsigned FLG_W         = 4;
   // Interrupt status bits: done, and carry-out of one.
   localparam int unsigned IRQ_DONE      = 0;
   localparam int unsigned IRQ_CARRY     = 1;
   localparam int unsigned IRQ_W         = 2;
   // Reset values and the slave error response.
   localparam logic [15:0] RST_WORD      = 16'h0000;
   localparam logic [3:0]  RST_FLAGS     = 4'h0;
   localparam logic [1:0]  RST_RESP_OK   = 2'h0;
   localparam logic [1:0]  RESP_SLVERR   = 2'h2;
   // Operation kinds decoded from the code.
   typedef enum logic [2:0] {
      WSR_NONE  = 3'b000,
      WSR_SHL   = 3'b001,
      WSR_SHR   = 3'b010,
      WSR_ROL   = 3'b011,
      WSR_SETC  = 3'b100,
      WSR_CLRC  = 3'b101
   } wsr_op_type;
endpackage
`default_nettype wire

/* include/wsr_alu_if.sv */
// Interface carrying one operation between the control file and the ALU.
`timescale 1ns/100ps
`default_nettype none
interface wsr_alu_if;
   wsr_pkg::wsr_op_type op;
   logic [15:0]         word_in;
   logic                carry_in;
   logic [15:0]         word_out;
   logic [3:0]          flags_out;
   logic                changes;
   modport ctl (output op, word_in, carry_in,
                input word_out, flags_out, changes);
   modport alu (input op, word_in, carry_in,
                output word_out, flags_out, changes);
endinterface
`default_nettype wire

/* logic/wsr_alu.sv */
// Combinational single-bit shift and rotate datapath with flag results.
`timescale 1ns/100ps
`default_nettype none
module wsr_alu (
   // Operation in, result out.
   wsr_alu_if.alu       a
);
   // Compute result word and the four flags for the decoded operation.
   always_comb begin
      logic       out_bit;
      out_bit     = 1'b0;
      a.word_out  = a.word_in;
      a.flags_out = wsr_pkg::RST_FLAGS;
      a.changes   = 1'b1;
      unique case (a.op)
         wsr_pkg::WSR_SHL: begin
            a.word_out = {a.word_in[14:0], 1'b0};
            out_bit    = a.word_in[15];
         end
         wsr_pkg::WSR_SHR: begin
            a.word_out = {1'b0, a.word_in[15:1]};
            out_bit    = a.word_in[0];
         end
         wsr_pkg::WSR_ROL: begin
            a.word_out = {a.word_in[14:0], a.carry_in};
            out_bit    = a.word_in[15];
         end
         default: begin
            a.changes = 1'b0;
         end
      endcase
      // Error always off; zero and negative follow the result.
      a.flags_out[wsr_pkg::FLG_ERR]   = 1'b0;
      a.flags_out[wsr_pkg::FLG_ZERO]  = (a.word_out == 16'h0000);
      a.flags_out[wsr_pkg::FLG_CARRY] = out_bit;
      // Right shift fills bit 15 with zero, so negative is off there too.
      a.flags_out[wsr_pkg::FLG_NEG]   = a.word_out[15];
   end
endmodule
`default_nettype wire

/* logic/wsr_top.sv */
// Shift and rotate unit with an AXI4-Lite register slave and interrupt.
// Summary of operation
// - Code 25 shifts the word left by one, fills bit 0 with zero and sends old bit 15 to carry.
// - Code 26 shifts the word right by one, fills bit 15 with zero, sends old bit 0 to carry and clears negative.
// - Code 27 rotates the word and carry as a 17-bit ring, old carry into bit 0 and old bit 15 into carry.
// - Every shift or rotate sets the zero flag exactly when the result is zero and clears the error flag.
// - Carry takes the value of the bit moved into it on every shift or rotate.
// - Left shift and rotate set negative from bit 15 of the result.
// - An operation acts once, only under a true execution condition, and otherwise leaves the word alone.
//
// Register access over AXI4-Lite and the address map were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module wsr_top (
   // Clock, reset and clock enable.
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        ce,
   // AXI4-Lite write address channel.
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   // AXI4-Lite write data channel.
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   // AXI4-Lite write response channel.
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   // AXI4-Lite read address channel.
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   // AXI4-Lite read data channel.
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // Flag outputs and interrupt.
   output logic             carry_flag,
   output logic             zero_result_flag,
   output logic             error_flag,
   output logic             negative_flag,
   output logic             irq
);
   // Register state.
   logic [15:0]       operand_word_r, operand_word_nxt;
   logic [3:0]        flags_r, flags_nxt;
   logic [wsr_pkg::IRQ_W-1:0] stat_r, stat_nxt, mask_r, mask_nxt;
   logic              irq_r, irq_nxt;
   // Bus state.
   logic              aw_have_r, aw_have_nxt, w_have_r, w_have_nxt;
   logic [7:0]        awaddr_r, awaddr_nxt;
   logic [31:0]       wdata_r, wdata_nxt;
   logic [3:0]        wstrb_r, wstrb_nxt;
   logic              bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt;
   logic [1:0]        bresp_r, bresp_nxt, rresp_r, rresp_nxt;
   logic [31:0]       rdata_r, rdata_nxt;
   logic              do_write, do_read;

   wsr_alu_if alu_bus ();

   wsr_alu u_alu (
      .a (alu_bus.alu)
   );

   // Map an operation code to its kind; unknown codes do nothing.
   function automatic wsr_pkg::wsr_op_type decode_op(input logic [7:0] c);
      wsr_pkg::wsr_op_type k;
      k = wsr_pkg::WSR_NONE;
      if (c == wsr_pkg::OP_SHL) k = wsr_pkg::WSR_SHL;
      if (c == wsr_pkg::OP_SHR) k = wsr_pkg::WSR_SHR;
      if (c == wsr_pkg::OP_ROL) k = wsr_pkg::WSR_ROL;
      if (c == wsr_pkg::OP_SET_CARRY) k = wsr_pkg::WSR_SETC;
      if (c == wsr_pkg::OP_CLR_CARRY) k = wsr_pkg::WSR_CLRC;
      return k;
   endfunction

   // Apply byte strobes to the low 16 bits of a word.
   function automatic logic [15:0] merge16(input logic [15:0] old,
                                           input logic [31:0] d,
                                           input logic [3:0]  s);
      logic [15:0] m;
      m = old;
      if (s[0]) m[7:0] = d[7:0];
      if (s[1]) m[15:8] = d[15:8];
      return m;
   endfunction

   // A write commits once address and data are both held and B is free.
   // Waiting for B to drain keeps one response from overwriting another.
   assign do_write = aw_have_r && w_have_r && !bvalid_r;
   assign do_read  = s_axi_arvalid && !rvalid_r;

   // Command from a control write; the condition bit gates execution.
   always_comb begin
      alu_bus.op       = wsr_pkg::WSR_NONE;
      alu_bus.word_in  = operand_word_r;
      alu_bus.carry_in = flags_r[wsr_pkg::FLG_CARRY];
      // Only a control write with a true condition issues an operation.
      if (do_write && awaddr_r == wsr_pkg::REG_CTRL && wstrb_r[1]
          && wdata_r[wsr_pkg::CTRL_COND_BIT]) begin
         alu_bus.op = decode_op(wdata_r[wsr_pkg::CTRL_OP_LSB +: 8]);
      end
   end

   // Write channel capture and register updates.
   always_comb begin
      aw_have_nxt      = aw_have_r;
      w_have_nxt       = w_have_r;
      awaddr_nxt       = awaddr_r;
      wdata_nxt        = wdata_r;
      wstrb_nxt        = wstrb_r;
      bvalid_nxt       = bvalid_r;
      bresp_nxt        = bresp_r;
      operand_word_nxt = operand_word_r;
      flags_nxt        = flags_r;
      stat_nxt         = stat_r;
      mask_nxt         = mask_r;

      // Address and data are held apart, so either may arrive first.
      if (s_axi_awvalid && !aw_have_r) begin
         aw_have_nxt = 1'b1;
         awaddr_nxt  = s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_have_r) begin
         w_have_nxt = 1'b1;
         wdata_nxt  = s_axi_wdata;
         wstrb_nxt  = s_axi_wstrb;
      end
      if (bvalid_r && s_axi_bready) begin
         bvalid_nxt = 1'b0;
      end

      if (do_write) begin
         aw_have_nxt = 1'b0;
         w_have_nxt  = 1'b0;
         bvalid_nxt  = 1'b1;
         bresp_nxt   = wsr_pkg::RST_RESP_OK;
         unique case (awaddr_r)
            wsr_pkg::REG_CTRL: ;
            wsr_pkg::REG_OPERAND:
               operand_word_nxt = merge16(operand_word_r, wdata_r, wstrb_r);
            wsr_pkg::REG_FLAGS:
               if (wstrb_r[0]) flags_nxt = wdata_r[wsr_pkg::FLG_W-1:0];
            wsr_pkg::REG_IRQ_STAT:
               if (wstrb_r[0]) stat_nxt = stat_r & ~wdata_r[wsr_pkg::IRQ_W-1:0];
            wsr_pkg::REG_IRQ_MASK:
               if (wstrb_r[0]) mask_nxt = wdata_r[wsr_pkg::IRQ_W-1:0];
            wsr_pkg::REG_RESULT: ;
            default: bresp_nxt = wsr_pkg::RESP_SLVERR;
         endcase
      end

      // Result and all flags land in the accepting cycle.
      if (alu_bus.changes) begin
         operand_word_nxt = alu_bus.word_out;
         flags_nxt        = alu_bus.flags_out;
         stat_nxt[wsr_pkg::IRQ_DONE] = 1'b1;
         if (alu_bus.flags_out[wsr_pkg::FLG_CARRY])
            stat_nxt[wsr_pkg::IRQ_CARRY] = 1'b1;
      end
      // Carry preset ahead of a rotate touches carry only.
      if (alu_bus.op == wsr_pkg::WSR_SETC)
         flags_nxt[wsr_pkg::FLG_CARRY] = 1'b1;
      if (alu_bus.op == wsr_pkg::WSR_CLRC)
         flags_nxt[wsr_pkg::FLG_CARRY] = 1'b0;
   end

   // Read channel: one-cycle answer, unmapped reads return SLVERR.
   always_comb begin
      rvalid_nxt = rvalid_r;
      rdata_nxt  = rdata_r;
      rresp_nxt  = rresp_r;

      if (rvalid_r && s_axi_rready) begin
         rvalid_nxt = 1'b0;
      end
      if (do_read) begin
         rvalid_nxt = 1'b1;
         rresp_nxt  = wsr_pkg::RST_RESP_OK;
         rdata_nxt  = 32'h0000_0000;
         unique case (s_axi_araddr)
            wsr_pkg::REG_CTRL: ;
            wsr_pkg::REG_OPERAND,
            wsr_pkg::REG_RESULT:   rdata_nxt[15:0] = operand_word_r;
            wsr_pkg::REG_FLAGS:    rdata_nxt[3:0]  = flags_r;
            wsr_pkg::REG_IRQ_STAT: rdata_nxt[1:0]  = stat_r;
            wsr_pkg::REG_IRQ_MASK: rdata_nxt[1:0]  = mask_r;
            default:               rresp_nxt = wsr_pkg::RESP_SLVERR;
         endcase
      end
   end

   // Interrupt level follows the next status, so it is registered too.
   always_comb begin
      irq_nxt = |(stat_nxt & mask_nxt);
   end

   // Register all state; clock enable low freezes everything.
   always_ff @(posedge clk) begin
      if (rst) begin
         aw_have_r      <= 1'b0;
         w_have_r       <= 1'b0;
         awaddr_r       <= 8'h00;
         wdata_r        <= 32'h0000_0000;
         wstrb_r        <= 4'h0;
         bvalid_r       <= 1'b0;
         bresp_r        <= wsr_pkg::RST_RESP_OK;
         rvalid_r       <= 1'b0;
         rresp_r        <= wsr_pkg::RST_RESP_OK;
         rdata_r        <= 32'h0000_0000;
         operand_word_r <= wsr_pkg::RST_WORD;
         flags_r        <= wsr_pkg::RST_FLAGS;
         stat_r         <= 2'h0;
         mask_r         <= 2'h0;
         irq_r          <= 1'b0;
      end else if (ce) begin
         aw_have_r      <= aw_have_nxt;
         w_have_r       <= w_have_nxt;
         awaddr_r       <= awaddr_nxt;
         wdata_r        <= wdata_nxt;
         wstrb_r        <= wstrb_nxt;
         bvalid_r       <= bvalid_nxt;
         bresp_r        <= bresp_nxt;
         rvalid_r       <= rvalid_nxt;
         rresp_r        <= rresp_nxt;
         rdata_r        <= rdata_nxt;
         operand_word_r <= operand_word_nxt;
         flags_r        <= flags_nxt;
         stat_r         <= stat_nxt;
         mask_r         <= mask_nxt;
         irq_r          <= irq_nxt;
      end
   end

   // Readies are a flop gated by the clock enable, so no handshake is
   // offered while state is frozen; every other output is a flop.
   assign s_axi_awready    = ce && !aw_have_r;
   assign s_axi_wready     = ce && !w_have_r;
   assign s_axi_bvalid     = bvalid_r;
   assign s_axi_bresp      = bresp_r;
   assign s_axi_arready    = ce && !rvalid_r;
   assign s_axi_rvalid     = rvalid_r;
   assign s_axi_rdata      = rdata_r;
   assign s_axi_rresp      = rresp_r;
   assign carry_flag       = flags_r[wsr_pkg::FLG_CARRY];
   assign zero_result_flag = flags_r[wsr_pkg::FLG_ZERO];
   assign error_flag       = flags_r[wsr_pkg::FLG_ERR];
   assign negative_flag    = flags_r[wsr_pkg::FLG_NEG];
   assign irq              = irq_r;

   // Checks on the datapath outcome, one cycle after acceptance.
   chk_shl_result: assert property (@(posedge clk) disable iff (rst)
      ce && alu_bus.op == wsr_pkg::WSR_SHL |=>
      operand_word_r == {$past(operand_word_r[14:0]), 1'b0}
      && carry_flag == $past(operand_word_r[15]))
      else $error("Left shift result or carry wrong.");

   chk_shr_result: assert property (@(posedge clk) disable iff (rst)
      ce && alu_bus.op == wsr_pkg::WSR_SHR |=>
      operand_word_r == {1'b0, $past(operand_word_r[15:1])}
      && carry_flag == $past(operand_word_r[0]) && !negative_flag)
      else $error("Right shift result, carry or negative wrong.");

   chk_rol_ring: assert property (@(posedge clk) disable iff (rst)
      ce && alu_bus.op == wsr_pkg::WSR_ROL |=>
      {carry_flag, operand_word_r} ==
      {$past(operand_word_r), $past(carry_flag)})
      else $error("Rotate through carry ring wrong.");

   // Flag checks after any shift or rotate.
   chk_zero_err: assert property (@(posedge clk) disable iff (rst)
      ce && alu_bus.changes |=>
      !error_flag && zero_result_flag == (operand_word_r == 16'h0000))
      else $error("Zero or error flag wrong after shift.");

   chk_carry_in: assert property (@(posedge clk) disable iff (rst)
      ce && alu_bus.changes |=> carry_flag ==
      ($past(alu_bus.op) == wsr_pkg::WSR_SHR ? $past(operand_word_r[0])
      : $past(operand_word_r[15])))
      else $error("Carry does not hold the bit shifted out.");

   chk_neg_left: assert property (@(posedge clk) disable iff (rst)
      ce && (alu_bus.op == wsr_pkg::WSR_SHL
      || alu_bus.op == wsr_pkg::WSR_ROL) |=>
      negative_flag == operand_word_r[15])
      else $error("Negative flag does not follow bit 15.");

   // Gating and timing of an operation.
   chk_no_cond: assert property (@(posedge clk) disable iff (rst)
      ce && do_write && awaddr_r == wsr_pkg::REG_CTRL
      && !wdata_r[wsr_pkg::CTRL_COND_BIT] |=>
      $stable(operand_word_r) && $stable(flags_r))
      else $error("Word changed without execution condition.");

   chk_carry_preset: assert property (@(posedge clk) disable iff (rst)
      ce && alu_bus.op == wsr_pkg::WSR_SETC |=> carry_flag)
      else $error("Set carry did not set carry.");

   chk_carry_clear: assert property (@(posedge clk) disable iff (rst)
      ce && alu_bus.op == wsr_pkg::WSR_CLRC |=> !carry_flag)
      else $error("Clear carry did not clear carry.");

   chk_same_cycle: assert property (@(posedge clk) disable iff (rst)
      ce && alu_bus.changes |=>
      operand_word_r == $past(alu_bus.word_out)
      && flags_r == $past(alu_bus.flags_out))
      else $error("Result not written in the accepting cycle.");

   // A low clock enable must hold the word, the flags, the status and the interrupt.
   chk_ce_freeze: assert property (@(posedge clk) disable iff (rst)
      !ce |=> $stable(operand_word_r) && $stable(flags_r)
      && $stable(stat_r) && $stable(irq))
      else $error("State moved while the clock enable was low.");

   // Each shift or rotate raises done, and a carry-out of one raises carry.
   chk_status_events: assert property (@(posedge clk) disable iff (rst)
      ce && alu_bus.changes |=> stat_r[wsr_pkg::IRQ_DONE]
      && (!carry_flag || stat_r[wsr_pkg::IRQ_CARRY]))
      else $error("Status event bit not raised by an operation.");

   // The pin is a registered copy of the masked status; it changes on
   // the same edge as the event and is never out of step with the status.
   chk_irq_level: assert property (@(posedge clk) disable iff (rst)
      irq == |(stat_r & mask_r))
      else $error("Interrupt level disagrees with status and mask.");

   // Holes in the map answer with an error and read as zero.
   chk_rd_hole: assert property (@(posedge clk) disable iff (rst)
      ce && do_read && s_axi_araddr > wsr_pkg::REG_IRQ_MASK |=>
      s_axi_rresp == wsr_pkg::RESP_SLVERR && s_axi_rdata == 32'h0000_0000)
      else $error("Unmapped read not refused.");

   chk_wr_hole: assert property (@(posedge clk) disable iff (rst)
      ce && do_write && awaddr_r > wsr_pkg::REG_IRQ_MASK |=>
      s_axi_bresp == wsr_pkg::RESP_SLVERR)
      else $error("Unmapped write not refused.");
endmodule
`default_nettype wire

/* bench/wsr_seq_model.sv */
// Sequencer model: an AXI4-Lite master that issues operations to the unit.
`timescale 1ns/100ps
`default_nettype none
module wsr_seq_model (
   // Clock.
   input  wire logic        clk,
   // Write channels.
   output logic [7:0]       s_axi_awaddr,
   output logic             s_axi_awvalid,
   input  wire logic        s_axi_awready,
   output logic [31:0]      s_axi_wdata,
   output logic [3:0]       s_axi_wstrb,
   output logic             s_axi_wvalid,
   input  wire logic        s_axi_wready,
   input  wire logic [1:0]  s_axi_bresp,
   input  wire logic        s_axi_bvalid,
   output logic             s_axi_bready,
   // Read channels.
   output logic [7:0]       s_axi_araddr,
   output logic             s_axi_arvalid,
   input  wire logic        s_axi_arready,
   input  wire logic [31:0] s_axi_rdata,
   input  wire logic [1:0]  s_axi_rresp,
   input  wire logic        s_axi_rvalid,
   output logic             s_axi_rready
);
   // Idle bus at time zero, so no input of the unit floats.
   initial begin
      s_axi_awaddr  = 8'h00;
      s_axi_awvalid = 1'b0;
      s_axi_wdata   = 32'h0;
      s_axi_wstrb   = 4'h0;
      s_axi_wvalid  = 1'b0;
      s_axi_bready  = 1'b0;
      s_axi_araddr  = 8'h00;
      s_axi_arvalid = 1'b0;
      s_axi_rready  = 1'b0;
   end

   // Offers address and data together and drops each once it is taken.
   // Released payloads are inverted so a stale value is never mistaken.
   task automatic wr(input logic [7:0] a, input logic [31:0] d,
                     output logic [1:0] resp, output logic ok);
      int n;
      ok = 1'b0;
      resp = 2'h3;
      @(posedge clk);
      s_axi_awaddr  <= a;
      s_axi_awvalid <= 1'b1;
      s_axi_wdata   <= d;
      s_axi_wstrb   <= 4'hF;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      for (n = 0; n < 64 && !ok; n++) begin
         @(posedge clk);
         if (s_axi_awvalid && s_axi_awready) begin
            s_axi_awvalid <= 1'b0;
            s_axi_awaddr  <= ~a;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            s_axi_wvalid <= 1'b0;
            s_axi_wdata  <= ~d;
         end
         if (s_axi_bvalid) begin
            resp = s_axi_bresp;
            ok = 1'b1;
            s_axi_bready <= 1'b0;
         end
      end
   endtask

   // Read: address held until taken, rready held until rvalid is seen.
   task automatic rd(input logic [7:0] a, output logic [31:0] d,
                     output logic [1:0] resp, output logic ok);
      int n;
      ok = 1'b0;
      d = 32'h0;
      resp = 2'h3;
      @(posedge clk);
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      for (n = 0; n < 64 && !ok; n++) begin
         @(posedge clk);
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arvalid <= 1'b0;
            s_axi_araddr  <= ~a;
         end
         if (s_axi_rvalid) begin
            d = s_axi_rdata;
            resp = s_axi_rresp;
            ok = 1'b1;
            s_axi_rready <= 1'b0;
         end
      end
   endtask

   // Control word: code in the low byte, execution condition in bit 8.
   task automatic issue(input logic [7:0] code, input logic cond,
                        output logic [1:0] resp, output logic ok);
      wr(wsr_pkg::REG_CTRL, {23'h0, cond, code}, resp, ok);
   endtask
endmodule
`default_nettype wire

/* bench/wsr_top_tb.sv */
// Self-checking bench for the shift and rotate unit.
`timescale 1ns/100ps
`default_nettype none
module wsr_top_tb;
   // Operation table: code, operand, carry preset.
   localparam logic [24:0] CASES [8] = '{
      {wsr_pkg::OP_SHL, 16'h8001, 1'b0}, {wsr_pkg::OP_SHL, 16'h8000, 1'b1},
      {wsr_pkg::OP_SHL, 16'h7FFF, 1'b1}, {wsr_pkg::OP_SHR, 16'h0001, 1'b1},
      {wsr_pkg::OP_SHR, 16'h8002, 1'b0}, {wsr_pkg::OP_ROL, 16'h8000, 1'b1},
      {wsr_pkg::OP_ROL, 16'h4000, 1'b0}, {wsr_pkg::OP_ROL, 16'h0000, 1'b0}};
   localparam logic [7:0]  ADDR_HOLE = 8'h20;
   logic        clk, rst, ce, irq;
   logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic        s_axi_rvalid, s_axi_rready, ok;
   logic        carry_flag, zero_result_flag, error_flag, negative_flag;
   logic [7:0]  s_axi_awaddr, s_axi_araddr;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
   logic [31:0] s_axi_wdata, s_axi_rdata, rd_data;
   int          num_errors, n_checks, i;

   wsr_top DUT (.clk, .rst, .ce, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
      .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .carry_flag,
      .zero_result_flag, .error_flag, .negative_flag, .irq);
   wsr_seq_model seq (.clk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
      .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready);

   // Free-running 100 MHz clock.
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // Closing report; the only place the run ends.
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   // A bus wait that ran out counts as a mismatch and ends the run.
   task automatic guard(input logic good);
      if (!good) begin
         num_errors++;
         $display("[FAIL] t=%0t bus wait expired", $time);
         end_of_test();
      end
   endtask

   // Compare tasks: one for values, one for bus responses.
   task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic chk_resp(input logic [1:0] exp);
      chk_val({30'h0, resp}, {30'h0, exp});
   endtask

   // Bus shorthands over the sequencer model.
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      seq.wr(a, d, resp, ok);
      guard(ok);
   endtask
   task automatic rd(input logic [7:0] a);
      seq.rd(a, rd_data, resp, ok);
      guard(ok);
   endtask
   task automatic go(input logic [7:0] code, input logic cond);
      seq.issue(code, cond, resp, ok);
      guard(ok);
   endtask

   // Flags in the register and at the pins: {neg, carry, zero, err}.
   task automatic chk_flags(input logic [3:0] exp);
      rd(wsr_pkg::REG_FLAGS);
      chk_val(rd_data, {28'h0, exp});
      chk_val({28'h0, negative_flag, carry_flag, zero_result_flag,
               error_flag}, {28'h0, exp});
   endtask

   // One operation; error and the opposite carry are preset so stale
   // values cannot pass.
   task automatic one_op(input logic [7:0] op, input logic [15:0] w,
                         input logic c);
      logic [15:0] ew;
      logic        ec;
      wr(wsr_pkg::REG_OPERAND, {16'h0, w});
      wr(wsr_pkg::REG_FLAGS, {28'h0, 1'b0, ~c, 1'b0, 1'b1});
      go(c ? wsr_pkg::OP_SET_CARRY : wsr_pkg::OP_CLR_CARRY, 1'b1);
      go(op, 1'b1);
      case (op)
         wsr_pkg::OP_SHL: {ec, ew} = {w, 1'b0};
         wsr_pkg::OP_SHR: {ew, ec} = {1'b0, w};
         default: {ec, ew} = {w, c};
      endcase
      rd(wsr_pkg::REG_OPERAND);
      chk_val(rd_data, {16'h0, ew});
      rd(wsr_pkg::REG_RESULT);
      chk_val(rd_data, {16'h0, ew});
      chk_flags({op != wsr_pkg::OP_SHR && ew[15], ec, ew == 16'h0, 1'b0});
   endtask

   // Main sequence.
   initial begin
      num_errors = 0;
      n_checks = 0;
      rst = 1'b1;
      ce = 1'b1;
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      for (i = 0; i < 24; i += 4) begin
         rd(8'(i));
         chk_val(rd_data, 32'h0);
      end
      chk_val({31'h0, irq}, 32'h0);
      $display("test reset done");
      for (i = 0; i < 8; i++) begin
         one_op(CASES[i][24:17], CASES[i][16:1], CASES[i][0]);
      end
      $display("test operations done");
      // False condition and an unused code leave word and flags alone.
      wr(wsr_pkg::REG_OPERAND, 32'h1234);
      wr(wsr_pkg::REG_FLAGS, 32'h0);
      go(wsr_pkg::OP_SHL, 1'b0);
      go(8'h28, 1'b1);
      rd(wsr_pkg::REG_OPERAND);
      chk_val(rd_data, 32'h1234);
      chk_flags(4'h0);
      $display("test condition done");
      // A low clock enable for three cycles withdraws the read address ready.
      ce <= 1'b0;
      repeat (3) @(posedge clk);
      chk_val({31'h0, s_axi_arready}, 32'h0);
      ce <= 1'b1;
      // Two rotates in a row: the second sees the carry of the first.
      wr(wsr_pkg::REG_OPERAND, 32'h8000);
      go(wsr_pkg::OP_CLR_CARRY, 1'b1);
      go(wsr_pkg::OP_ROL, 1'b1);
      go(wsr_pkg::OP_ROL, 1'b1);
      rd(wsr_pkg::REG_OPERAND);
      chk_val(rd_data, 32'h0001);
      chk_flags(4'h0);
      $display("test chained done");
      // Interrupt: raise both events, unmask carry, then clear carry.
      wr(wsr_pkg::REG_OPERAND, 32'h8000);
      wr(wsr_pkg::REG_IRQ_STAT, 32'h3);
      go(wsr_pkg::OP_SHL, 1'b1);
      rd(wsr_pkg::REG_IRQ_STAT);
      chk_val(rd_data, 32'h3);
      chk_val({31'h0, irq}, 32'h0);
      wr(wsr_pkg::REG_IRQ_MASK, 32'h2);
      repeat (2) @(posedge clk);
      chk_val({31'h0, irq}, 32'h1);
      wr(wsr_pkg::REG_IRQ_STAT, 32'h2);
      repeat (2) @(posedge clk);
      chk_val({31'h0, irq}, 32'h0);
      rd(wsr_pkg::REG_IRQ_STAT);
      chk_val(rd_data, 32'h1);
      $display("test interrupt done");
      // Unmapped place and a write to the read-only result.
      rd(ADDR_HOLE);
      chk_resp(wsr_pkg::RESP_SLVERR);
      chk_val(rd_data, 32'h0);
      wr(ADDR_HOLE, 32'hFFFF);
      chk_resp(wsr_pkg::RESP_SLVERR);
      wr(wsr_pkg::REG_RESULT, 32'hFFFF);
      chk_resp(wsr_pkg::RST_RESP_OK);
      rd(wsr_pkg::REG_RESULT);
      chk_val(rd_data, 32'h0);
      $display("test bus done");
      end_of_test();
   end
endmodule
`default_nettype wire
